// [design/rltpg_pulse_xing.sv]
// Purpose: Carries single-cycle events between two unrelated clocks
// Assumes: Events are spaced by at least four destination clock cycles
// Notes: Toggle in source domain, three flops and edge detect in destination
`default_nettype none
module rltpg_pulse_xing (
	input wire logic src_clk_i,
	input wire logic src_rst_i,
	input wire logic src_pulse_i,
	input wire logic dst_clk_i,
	input wire logic dst_rst_i,
	output logic dst_pulse_o
);
	logic tog_r;
	logic meta_r;
	logic sync_r;
	logic last_r;

	// Source toggles once per event
	always_ff @(posedge src_clk_i or posedge src_rst_i) begin
		if (src_rst_i) begin
			tog_r <= 1'h0;
		end else begin
			tog_r <= tog_r ^ src_pulse_i;
		end
	end

	// Destination synchroniser and change detector
	always_ff @(posedge dst_clk_i or posedge dst_rst_i) begin
		if (dst_rst_i) begin
			meta_r <= 1'h0;
			sync_r <= 1'h0;
			last_r <= 1'h0;
		end else begin
			meta_r <= tog_r;
			sync_r <= meta_r;
			last_r <= sync_r;
		end
	end

	assign dst_pulse_o = sync_r ^ last_r;
endmodule
`default_nettype wire

// [design/rltpg_sync2.sv]
// Purpose: Two-flop synchroniser for levels entering a clock domain
// Assumes: Each bit is an independent, slowly changing level
// Notes: First stage feeds only the second stage
`default_nettype none
module rltpg_sync2 #(
	parameter int W = 1
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic [W-1:0] d_i,
	output logic [W-1:0] q_o
);
	logic [W-1:0] meta_r;
	logic [W-1:0] sync_r;

	// Two stages, reset to zero
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			meta_r <= '0;
			sync_r <= '0;
		end else begin
			meta_r <= d_i;
			sync_r <= meta_r;
		end
	end

	assign q_o = sync_r;
endmodule
`default_nettype wire

// [design/rltpg_top.sv]
// Purpose: Test-pattern line generator in front of the video link output
// Assumes: Sensor pixels arrive already processed, on the link clock
// Notes: Configuration crosses to the link clock by a request/ack handshake
//
// Notes on behaviour
// - Test mode replaces sensor data; six patterns
// - Pattern one: gray ramp from zero each line
// - Trigger modes: one line per trigger cycle
// - Free-run: one line per internal sync cycle
// - Pattern two: gray ramp, first line starts zero
// - Pattern two start value rises each line
// - Pattern three left half: 8-bit pixel ramp
// - Pattern three right half: ramp across lines
// - Zero delay: right half red equals green equals blue
// - Delay N: green is red+N, blue green+N
// - Delay applied only in 8-bit depth
// - Pattern four: red ramp, green blue zero
// - Pattern five: green ramp, red blue zero
// - Pattern six: blue ramp, red green zero
// - Gain, offset, exposure never reach pattern pixels
`default_nettype none
module rltpg_top #(
	parameter int FREE_LINE_CYCLES = rltpg_pkg::FREE_LINE_CYC
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pix_clk_i,
	input var rltpg_pkg::rltpg_cfg_s cfg_i,
	output logic cfg_busy_o,
	input wire logic ext_line_trigger_i,
	input var rltpg_pkg::rltpg_pix_s sensor_pix_i,
	output rltpg_pkg::rltpg_pix_s pix_o,
	output logic test_active_o
);
	////////////////////////////////////////////////////////////////////////
	// System-domain declarations
	rltpg_pkg::rltpg_cfg_s hold_r;
	logic busy_r;
	logic req_send;
	logic ack_sys;
	logic cfg_changed;
	logic [rltpg_pkg::FREE_CNT_W-1:0] free_cnt_r;
	logic [rltpg_pkg::FREE_CNT_W-1:0] free_cnt_nxt;
	logic free_wrap;
	logic free_tick;

	////////////////////////////////////////////////////////////////////////
	// Link-domain declarations
	logic rst_meta_r;
	logic rst_link_r;
	logic req_link;
	logic free_tick_link;
	logic trig_sync;
	logic trig_last_r;
	logic trig_rise;
	logic line_go;
	logic test_on;
	rltpg_pkg::rltpg_cfg_s cfg_l_r;
	rltpg_pkg::rltpg_line_e state_r;
	rltpg_pkg::rltpg_line_e state_nxt;
	logic [rltpg_pkg::PIXCNT_W-1:0] pix_cnt_r;
	logic [rltpg_pkg::PIXCNT_W-1:0] pix_cnt_nxt;
	logic [rltpg_pkg::PIX_W-1:0] off_r;
	logic [rltpg_pkg::PIX_W-1:0] off_nxt;
	logic line_end;
	logic pat_new;
	rltpg_pkg::rltpg_pix_s pix_r;
	rltpg_pkg::rltpg_pix_s pix_nxt;
	rltpg_pkg::rltpg_pix_s pat_pix;

	////////////////////////////////////////////////////////////////////////
	// Configuration handshake, system side
	assign cfg_changed = (cfg_i != hold_r);
	assign req_send = !busy_r && cfg_changed;

	// Hold a snapshot until the link side has taken it
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			hold_r <= rltpg_pkg::CFG_RESET;
			busy_r <= 1'h0;
		end else if (req_send) begin
			hold_r <= cfg_i;
			busy_r <= 1'h1;
		end else if (ack_sys) begin
			busy_r <= 1'h0;
		end
	end

	assign cfg_busy_o = busy_r;

	rltpg_pulse_xing u_req_xing (
		.src_clk_i(clk_i),
		.src_rst_i(rst_i),
		.src_pulse_i(req_send),
		.dst_clk_i(pix_clk_i),
		.dst_rst_i(rst_link_r),
		.dst_pulse_o(req_link)
	);

	rltpg_pulse_xing u_ack_xing (
		.src_clk_i(pix_clk_i),
		.src_rst_i(rst_link_r),
		.src_pulse_i(req_link),
		.dst_clk_i(clk_i),
		.dst_rst_i(rst_i),
		.dst_pulse_o(ack_sys)
	);

	////////////////////////////////////////////////////////////////////////
	// Free-run internal line sync, system side
	assign free_wrap = (free_cnt_r == rltpg_pkg::FREE_CNT_W'(FREE_LINE_CYCLES - 1));
	assign free_cnt_nxt = (free_wrap || !cfg_i.free_run) ? '0 : free_cnt_r + 1'b1;
	assign free_tick = free_wrap && cfg_i.free_run;

	// Period counter runs only in free-run mode
	always_ff @(posedge clk_i or posedge rst_i) begin
		if (rst_i) begin
			free_cnt_r <= '0;
		end else begin
			free_cnt_r <= free_cnt_nxt;
		end
	end

	rltpg_pulse_xing u_free_xing (
		.src_clk_i(clk_i),
		.src_rst_i(rst_i),
		.src_pulse_i(free_tick),
		.dst_clk_i(pix_clk_i),
		.dst_rst_i(rst_link_r),
		.dst_pulse_o(free_tick_link)
	);

	////////////////////////////////////////////////////////////////////////
	// Link-domain reset: asynchronous assert, synchronous release
	always_ff @(posedge pix_clk_i or posedge rst_i) begin
		if (rst_i) begin
			rst_meta_r <= 1'h1;
			rst_link_r <= 1'h1;
		end else begin
			rst_meta_r <= 1'h0;
			rst_link_r <= rst_meta_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// External line trigger: synchronise and take rising edges
	rltpg_sync2 #(
		.W(1)
	) u_trig_sync (
		.clk_i(pix_clk_i),
		.rst_i(rst_link_r),
		.d_i(ext_line_trigger_i),
		.q_o(trig_sync)
	);

	always_ff @(posedge pix_clk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			trig_last_r <= 1'h0;
		end else begin
			trig_last_r <= trig_sync;
		end
	end

	assign trig_rise = trig_sync && !trig_last_r;

	// Line source picked by exposure mode
	assign line_go = cfg_l_r.free_run ? free_tick_link : trig_rise;
	assign test_on = (cfg_l_r.pat != rltpg_pkg::PAT_OFF) && (cfg_l_r.pat != rltpg_pkg::PAT_SPARE);

	////////////////////////////////////////////////////////////////////////
	// Line sequencer: one line per accepted start, starts ignored mid-line
	assign line_end = (state_r == rltpg_pkg::LN_ACTIVE) && (pix_cnt_r == rltpg_pkg::LINE_LAST);
	assign pat_new = req_link && (hold_r.pat != cfg_l_r.pat);

	always_comb begin
		state_nxt = state_r;
		pix_cnt_nxt = pix_cnt_r;
		case (state_r)
			rltpg_pkg::LN_IDLE: begin
				if (line_go && test_on) begin
					state_nxt = rltpg_pkg::LN_ACTIVE;
					pix_cnt_nxt = rltpg_pkg::PIXCNT_ZERO;
				end
			end
			rltpg_pkg::LN_ACTIVE: begin
				pix_cnt_nxt = pix_cnt_r + rltpg_pkg::PIXCNT_ONE;
				if (line_end || !test_on) begin
					state_nxt = rltpg_pkg::LN_IDLE;
				end
			end
			default: begin
				state_nxt = rltpg_pkg::LN_IDLE;
			end
		endcase
	end

	// Offset moves one step per finished line, cleared on a new pattern
	assign off_nxt = pat_new ? rltpg_pkg::PIX_ZERO :
		line_end ? off_r + rltpg_pkg::OFF_ONE : off_r;

	always_ff @(posedge pix_clk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			state_r <= rltpg_pkg::LN_IDLE;
			pix_cnt_r <= rltpg_pkg::PIXCNT_ZERO;
			off_r <= rltpg_pkg::PIX_ZERO;
		end else begin
			state_r <= state_nxt;
			pix_cnt_r <= pix_cnt_nxt;
			off_r <= off_nxt;
		end
	end

	// Take the held configuration when the request arrives
	always_ff @(posedge pix_clk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			cfg_l_r <= rltpg_pkg::CFG_RESET;
		end else if (req_link) begin
			cfg_l_r <= hold_r;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Pattern arithmetic
	logic [rltpg_pkg::PIX_W-1:0] depth_mask;
	logic [rltpg_pkg::PIX_W-1:0] ramp;
	logic [rltpg_pkg::PIX_W-1:0] ramp8;
	logic [rltpg_pkg::PIX_W-1:0] moving;
	logic [rltpg_pkg::PIX_W-1:0] sc_step;
	logic [rltpg_pkg::PIX_W-1:0] right_r;
	logic [rltpg_pkg::PIX_W-1:0] right_g;
	logic [rltpg_pkg::PIX_W-1:0] right_b;
	logic right_half;

	assign depth_mask = cfg_l_r.depth_10b ? rltpg_pkg::MASK_10B : rltpg_pkg::MASK_8B;
	assign ramp = pix_cnt_r[rltpg_pkg::PIX_W-1:0] & depth_mask;
	assign ramp8 = pix_cnt_r[rltpg_pkg::PIX_W-1:0] & rltpg_pkg::MASK_8B;
	assign moving = rltpg_pkg::PIX_W'(pix_cnt_r[rltpg_pkg::PIX_W-1:0] + off_r) & depth_mask;
	assign right_half = (pix_cnt_r >= rltpg_pkg::LINE_HALF);

	// Delay step exists only in 8-bit depth, zero gives equal colours
	assign sc_step = cfg_l_r.depth_10b ? rltpg_pkg::PIX_ZERO :
		rltpg_pkg::PIX_W'(cfg_l_r.sc_delay);
	assign right_r = off_r & rltpg_pkg::MASK_8B;
	assign right_g = rltpg_pkg::PIX_W'(off_r + sc_step) & rltpg_pkg::MASK_8B;
	assign right_b = rltpg_pkg::PIX_W'(off_r + sc_step + sc_step) & rltpg_pkg::MASK_8B;

	// Colour selection per pattern, built from counters only
	always_comb begin
		pat_pix = rltpg_pkg::PIX_RESET;
		pat_pix.lval = (state_r == rltpg_pkg::LN_ACTIVE);
		case (cfg_l_r.pat)
			rltpg_pkg::PAT_GRAY: begin
				pat_pix.red = ramp;
				pat_pix.green = ramp;
				pat_pix.blue = ramp;
			end
			rltpg_pkg::PAT_MOVING: begin
				pat_pix.red = moving;
				pat_pix.green = moving;
				pat_pix.blue = moving;
			end
			rltpg_pkg::PAT_SPLIT: begin
				if (right_half) begin
					pat_pix.red = right_r;
					pat_pix.green = right_g;
					pat_pix.blue = right_b;
				end else begin
					pat_pix.red = ramp8;
					pat_pix.green = ramp8;
					pat_pix.blue = ramp8;
				end
			end
			rltpg_pkg::PAT_RED: begin
				pat_pix.red = ramp;
			end
			rltpg_pkg::PAT_GREEN: begin
				pat_pix.green = ramp;
			end
			rltpg_pkg::PAT_BLUE: begin
				pat_pix.blue = ramp;
			end
			default: begin
				pat_pix = rltpg_pkg::PIX_RESET;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Output mux: sensor path fully bypassed in test mode
	assign pix_nxt = test_on ? pat_pix : sensor_pix_i;

	always_ff @(posedge pix_clk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			pix_r <= rltpg_pkg::PIX_RESET;
		end else begin
			pix_r <= pix_nxt;
		end
	end

	// Test status as seen by the link side
	always_ff @(posedge pix_clk_i or posedge rst_link_r) begin
		if (rst_link_r) begin
			test_active_o <= 1'h0;
		end else begin
			test_active_o <= test_on;
		end
	end

	assign pix_o = pix_r;
endmodule
`default_nettype wire

// [inc/rltpg_pkg.sv]
// Purpose: Shared constants and types for the RGB line test-pattern generator
// Assumes: 50 MHz system clock, pixel link clock from the video link side
// Notes: Pattern codes follow the selection order 0 (off) to 6
`default_nettype none
package rltpg_pkg;
	////////////////////////////////////////////////////////////////////////
	// Timing
	localparam int CLK_PERIOD_NS = 20;
	localparam int FREE_LINE_US = 100;
	localparam int FREE_LINE_CYC = (FREE_LINE_US * 1000) / CLK_PERIOD_NS;
	localparam int FREE_CNT_W = 24;

	////////////////////////////////////////////////////////////////////////
	// Line geometry and pixel depth
	localparam int PIX_W = 10;
	localparam int PIXCNT_W = 12;
	localparam int SC_DELAY_W = 6;
	localparam logic [11:0] LINE_LAST = 12'h0831;
	localparam logic [11:0] LINE_HALF = 12'h0419;
	localparam logic [11:0] PIXCNT_ZERO = 12'h0000;
	localparam logic [11:0] PIXCNT_ONE = 12'h0001;
	localparam logic [9:0] MASK_8B = 10'h00ff;
	localparam logic [9:0] MASK_10B = 10'h03ff;
	localparam logic [9:0] PIX_ZERO = 10'h0000;
	localparam logic [9:0] OFF_ONE = 10'h0001;

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef enum logic [2:0] {
		PAT_OFF, PAT_GRAY, PAT_MOVING, PAT_SPLIT, PAT_RED, PAT_GREEN, PAT_BLUE, PAT_SPARE
	} rltpg_pat_e;

	typedef enum logic {LN_IDLE, LN_ACTIVE} rltpg_line_e;

	typedef struct packed {
		rltpg_pat_e pat;
		logic depth_10b;
		logic free_run;
		logic [SC_DELAY_W-1:0] sc_delay;
	} rltpg_cfg_s;

	typedef struct packed {
		logic lval;
		logic [PIX_W-1:0] red;
		logic [PIX_W-1:0] green;
		logic [PIX_W-1:0] blue;
	} rltpg_pix_s;

	localparam rltpg_cfg_s CFG_RESET = '{PAT_OFF, 1'h0, 1'h0, 6'h00};
	localparam rltpg_pix_s PIX_RESET = '{1'h0, 10'h000, 10'h000, 10'h000};
endpackage
`default_nettype wire

// [tb/rltpg_grab.sv]
// Purpose: Frame grabber model, keeps three sample pixels per line
// Assumes: Lines are framed by lval on the link clock
// Notes: Reports on the first low cycle after a line
`default_nettype none
module rltpg_grab (
	input wire logic clk_i,
	input var rltpg_pkg::rltpg_pix_s pix_i,
	output logic done_o,
	output logic [11:0] len_o,
	output rltpg_pkg::rltpg_pix_s [2:0] s_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] n = 12'h0000;
	initial done_o = 1'b0;
	// Count pixels and capture pixels 0, 1000 and 2000
	always @(posedge clk_i) begin
		done_o <= !pix_i.lval && n != 12'h0000;
		len_o <= n;
		if (pix_i.lval) begin
			if (n == 12'h0000) s_o[0] <= pix_i;
			if (n == 12'h03e8) s_o[1] <= pix_i;
			if (n == 12'h07d0) s_o[2] <= pix_i;
			n <= n + 12'h0001;
		end else n <= 12'h0000;
	end
endmodule
`default_nettype wire

// [tb/rltpg_top_properties.sv]
// Purpose: Port checks for the line test-pattern generator
// Assumes: Config changes only between lines
// Notes: Pixel index is rebuilt from lval
`default_nettype none
module rltpg_top_properties #(
	parameter int FREE_LINE_CYCLES = 5000
) (
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic pix_clk_i,
	input var rltpg_pkg::rltpg_cfg_s cfg_i,
	input wire logic cfg_busy_o,
	input wire logic ext_line_trigger_i,
	input var rltpg_pkg::rltpg_pix_s sensor_pix_i,
	input var rltpg_pkg::rltpg_pix_s pix_o,
	input wire logic test_active_o
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [11:0] idx_r;
	default clocking cb @(posedge pix_clk_i);
	endclocking
	default disable iff (rst_i);
	////////////////////////////////////////////////////////////////////////
	// Pixel index within the line
	always_ff @(posedge pix_clk_i or posedge rst_i) begin
		if (rst_i) idx_r <= 12'h0000;
		else idx_r <= pix_o.lval ? idx_r + 12'h0001 : 12'h0000;
	end
	// Ramp, delay step and active pattern
	wire logic [9:0] m = cfg_i.depth_10b ? 10'h03ff : 10'h00ff;
	wire logic [9:0] v = idx_r[9:0] & m;
	wire logic [9:0] d = cfg_i.depth_10b ? 10'h0000 : {4'h0, cfg_i.sc_delay};
	wire logic [9:0] r = pix_o.red;
	wire logic [9:0] g = pix_o.green;
	wire logic [9:0] b = pix_o.blue;
	wire logic [2:0] p = (pix_o.lval && test_active_o && !cfg_busy_o) ? cfg_i.pat : 3'h0;
	wire logic rt = idx_r >= 12'h0419;
	////////////////////////////////////////////////////////////////////////
	// Line framing and pixel values
	property p_len; $fell(pix_o.lval) && test_active_o |-> idx_r == 12'h0832; endproperty
	a_len: assert property (p_len) else $error("line length wrong");
	property p_trig; $rose(ext_line_trigger_i) && test_active_o && !pix_o.lval
		&& !cfg_i.free_run && !cfg_busy_o |-> ##[2:8] $rose(pix_o.lval); endproperty
	a_trig: assert property (p_trig) else $error("no line after trigger");
	property p_gray; p == rltpg_pkg::PAT_GRAY |-> r == v && g == v && b == v; endproperty
	a_gray: assert property (p_gray) else $error("gray ramp wrong");
	property p_move; p == rltpg_pkg::PAT_MOVING && idx_r != 12'h0000
		|-> r == (($past(r) + 10'h0001) & m) && g == r && b == r; endproperty
	a_move: assert property (p_move) else $error("moving ramp wrong");
	property p_left; p == rltpg_pkg::PAT_SPLIT && !rt
		|-> r == {2'h0, idx_r[7:0]} && g == r && b == r; endproperty
	a_left: assert property (p_left) else $error("left half wrong");
	property p_right; p == rltpg_pkg::PAT_SPLIT && rt
		|-> g == ((r + d) & 10'h00ff) && b == ((g + d) & 10'h00ff); endproperty
	a_right: assert property (p_right) else $error("right half wrong");
	property p_hold; p == rltpg_pkg::PAT_SPLIT && idx_r > 12'h0419 |-> $stable(pix_o); endproperty
	a_hold: assert property (p_hold) else $error("right half not flat");
	property p_red; p == rltpg_pkg::PAT_RED |-> r == v && g == 10'h0000 && b == 10'h0000; endproperty
	a_red: assert property (p_red) else $error("red ramp wrong");
	property p_grn; p == rltpg_pkg::PAT_GREEN |-> g == v && r == 10'h0000 && b == r; endproperty
	a_grn: assert property (p_grn) else $error("green ramp wrong");
	property p_blu; p == rltpg_pkg::PAT_BLUE |-> b == v && r == 10'h0000 && g == r; endproperty
	a_blu: assert property (p_blu) else $error("blue ramp wrong");
	property p_pass; !test_active_o && !$past(test_active_o) && !$past(test_active_o, 2)
		|-> pix_o == $past(sensor_pix_i); endproperty
	a_pass: assert property (p_pass) else $error("sensor data not passed");
endmodule
bind rltpg_top rltpg_top_properties #(.FREE_LINE_CYCLES(FREE_LINE_CYCLES)) chk (
	.clk_i(clk_i), .rst_i(rst_i), .pix_clk_i(pix_clk_i), .cfg_i(cfg_i), .cfg_busy_o(cfg_busy_o),
	.ext_line_trigger_i(ext_line_trigger_i), .sensor_pix_i(sensor_pix_i), .pix_o(pix_o),
	.test_active_o(test_active_o));
`default_nettype wire

// [tb/rltpg_top_tb.sv]
// Purpose: Self-checking bench for the line test-pattern generator
// Assumes: System clock 20 ns, link clock 80 ns
// Notes: Lines are judged by length and three sample pixels
`default_nettype none
module rltpg_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 1'b0;
	logic pix_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic trig = 1'b0;
	logic rnd = 1'b0;
	logic busy, act, done;
	logic [11:0] len;
	rltpg_pkg::rltpg_cfg_s cfg = rltpg_pkg::CFG_RESET;
	rltpg_pkg::rltpg_pix_s sens = rltpg_pkg::PIX_RESET;
	rltpg_pkg::rltpg_pix_s pix;
	rltpg_pkg::rltpg_pix_s [2:0] smp;
	rltpg_pkg::rltpg_pix_s q [$];
	int mismatches = 0;
	int total_checks = 0;
	int seed = 27497;
	int off = 0;
	////////////////////////////////////////////////////////////////////////
	// Clocks, the link clock offset in phase
	always #10 clk_i = ~clk_i;
	initial #7 forever #40 pix_clk_i = ~pix_clk_i;
	rltpg_top #(.FREE_LINE_CYCLES(8600)) uut (.clk_i(clk_i), .rst_i(rst_i),
		.pix_clk_i(pix_clk_i), .cfg_i(cfg), .cfg_busy_o(busy), .ext_line_trigger_i(trig),
		.sensor_pix_i(sens), .pix_o(pix), .test_active_o(act));
	rltpg_grab fg (.clk_i(pix_clk_i), .pix_i(pix), .done_o(done), .len_o(len), .s_o(smp));
	// Random sensor data, never to be seen in a pattern
	always @(negedge clk_i) if (rnd) sens <= {1'b0, 30'($random(seed))};
	////////////////////////////////////////////////////////////////////////
	task automatic check(input logic [30:0] seen, input logic [30:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", total_checks, mismatches);
		if (mismatches == 0 && total_checks > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Expected pixel k of the next line
	function automatic rltpg_pkg::rltpg_pix_s ex(input int k);
		logic [9:0] m, v, d, o;
		m = cfg.depth_10b ? 10'h03ff : 10'h00ff;
		v = 10'(k) & m;
		d = cfg.depth_10b ? 10'h0000 : 10'(cfg.sc_delay);
		o = 10'(off) & 10'h00ff;
		case (cfg.pat)
			rltpg_pkg::PAT_GRAY: ex = '{1'b1, v, v, v};
			rltpg_pkg::PAT_MOVING: ex = '{1'b1, 10'(k + off) & m, 10'(k + off) & m, 10'(k + off) & m};
			rltpg_pkg::PAT_SPLIT: begin
				if (k < 1049) ex = '{1'b1, v & 10'h00ff, v & 10'h00ff, v & 10'h00ff};
				else ex = '{1'b1, o, (o + d) & 10'h00ff, (o + d + d) & 10'h00ff};
			end
			rltpg_pkg::PAT_RED: ex = '{1'b1, v, 10'h0000, 10'h0000};
			rltpg_pkg::PAT_GREEN: ex = '{1'b1, 10'h0000, v, 10'h0000};
			default: ex = '{1'b1, 10'h0000, 10'h0000, v};
		endcase
	endfunction
	task automatic pulse();
		trig = 1'b1;
		repeat (24) @(negedge clk_i);
		trig = 1'b0;
	endtask
	// Apply a config, wait out the crossing, check test mode
	task automatic set(input logic [2:0] p, input logic d, input logic f, input logic [5:0] n);
		int i;
		if (p != cfg.pat) off = 0;
		cfg = '{rltpg_pkg::rltpg_pat_e'(p), d, f, n};
		repeat (2) @(negedge clk_i);
		for (i = 0; i < 200 && busy !== 1'b0; i++) @(negedge clk_i);
		if (busy !== 1'b0) mismatches++;
		if (busy !== 1'b0) results();
		repeat (40) @(negedge clk_i);
		check(31'(act), 31'(p != 3'h0 && p != 3'h7));
	endtask
	// One line: note the samples, start it unless free-running and wait for the grabber
	task automatic line();
		int i;
		q.push_back(ex(0));
		q.push_back(ex(1000));
		q.push_back(ex(2000));
		if (!cfg.free_run) pulse();
		for (i = 0; i < 19000 && q.size() != 0; i++) @(negedge clk_i);
		if (q.size() != 0) mismatches++;
		if (q.size() != 0) results();
		off++;
	endtask
	////////////////////////////////////////////////////////////////////////
	// Compare each captured line with the oldest notes, failing any line with fewer than three notes queued
	always @(posedge pix_clk_i) begin
		if (done === 1'b1 && q.size() < 3) check(31'(len), 31'h0000_0000);
		else if (done === 1'b1) begin
			check(31'(len), 31'h0000_0832);
			check(smp[0], q.pop_front());
			check(smp[1], q.pop_front());
			check(smp[2], q.pop_front());
		end
	end
	// Main sequence
	initial begin
		repeat (5) @(negedge pix_clk_i);
		@(negedge clk_i);
		rst_i = 1'b0;
		repeat (20) @(negedge clk_i);
		rnd = 1'b1;
		set(3'h1, 1'b0, 1'b0, 6'h00);
		line();
		set(3'h2, 1'b1, 1'b0, 6'h00);
		repeat (2) line();
		set(3'h3, 1'b0, 1'b0, 6'($random(seed)) | 6'h01);
		line();
		set(3'h3, 1'b1, 1'b0, cfg.sc_delay);
		line();
		set(3'h4, 1'b1, 1'b0, 6'h00);
		line();
		set(3'h5, 1'b0, 1'b0, 6'h00);
		line();
		set(3'h0, 1'b0, 1'b0, 6'h00);
		pulse();
		repeat (200) @(negedge clk_i);
		check(31'(pix.lval), 31'h0000_0000);
		// Spare code behaves as test off
		set(3'h7, 1'b0, 1'b0, 6'h00);
		pulse();
		repeat (200) @(negedge clk_i);
		check(31'(pix.lval), 31'h0000_0000);
		set(3'h6, 1'b1, 1'b1, 6'h00);
		line();
		set(3'h6, 1'b1, 1'b0, 6'h00);
		results();
	end
endmodule
`default_nettype wire
